// File: svag_defines.vh
/*
 * constants for the speech volume and gain control block: register
 * offsets, field positions, reset values and timing counts.
 * assumes inclusion by bare name from the design file only.
 */
`ifndef SVAG_DEFINES_VH
`define SVAG_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SVAG_OFF_CTRL 8'h00
`define SVAG_OFF_PLAY_VOL 8'h04
`define SVAG_OFF_REC_VOL 8'h08
`define SVAG_OFF_MIN_GAIN 8'h0C
`define SVAG_OFF_MAX_GAIN 8'h10
`define SVAG_OFF_START_GAIN 8'h14
`define SVAG_OFF_HOLD_TIME 8'h18
`define SVAG_OFF_ATTACK_TC 8'h1C
`define SVAG_OFF_DECAY_TC 8'h20
`define SVAG_OFF_THRESHOLD 8'h24
`define SVAG_OFF_STATUS 8'h28
`define SVAG_OFF_GAIN 8'h2C

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define SVAG_CTRL_AGC_EN 0
`define SVAG_CTRL_SPKR 1
`define SVAG_CTRL_ALAW 2
`define SVAG_CTRL_COMP 3
`define SVAG_CTRL_MASK 32'h0000000F

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SVAG_RST_VOL 16'h0100
`define SVAG_RST_MIN_GAIN 16'h0020
`define SVAG_RST_MAX_GAIN 16'h1000
`define SVAG_RST_START_GAIN 16'h0800
`define SVAG_RST_HOLD_TIME 16'h1F40
`define SVAG_RST_ATTACK_TC 16'h0005
`define SVAG_RST_DECAY_TC 16'h000D
`define SVAG_RST_THRESHOLD 16'h2000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SVAG_CLK_MHZ 250
`define SVAG_HOLD_STEP_US 250
`define SVAG_HOLD_STEP_CYC (`SVAG_HOLD_STEP_US * `SVAG_CLK_MHZ)
`define SVAG_FAR_SLOW_SHIFT 4'h2

`endif

// File: svag_core.v
/*
 * speech sample path gain block: record/playback volume, companded
 * sample alignment and record-path automatic gain control, with an
 * ahb-lite register slave.
 * assumes one clock hclk, single-word ahb transfers, samples arriving
 * as one-cycle strobes from logic on the same clock.
 */
`timescale 1ns/10ps
`include "svag_defines.vh"

module svag_core #(
   parameter HOLD_STEP_CYC = `SVAG_HOLD_STEP_CYC
) (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire rec_valid,
   input wire [15:0] rec_sample,
   output reg rec_out_valid,
   output reg [15:0] rec_out_sample,
   input wire play_valid,
   input wire [15:0] play_sample,
   output reg play_out_valid,
   output reg [15:0] play_out_sample,
   input wire far_end_talk
);

   // ------------------------------------------------------------
   // states, one-hot
   // ------------------------------------------------------------
   localparam ST_OFF = 4'b0001;
   localparam ST_ATTACK = 4'b0010;
   localparam ST_HOLD = 4'b0100;
   localparam ST_DECAY = 4'b1000;

   // threshold reset value cut to the 15 bits that are stored
   localparam [15:0] THRESH_RST = `SVAG_RST_THRESHOLD;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // q8 multiply, low 16 bits of the shifted product kept
   function [15:0] q8_scale;
      input [15:0] smp;
      input [15:0] vol;
      reg [32:0] prod;
      begin
         prod = $signed({smp[15], smp}) * $signed({1'b0, vol});
         q8_scale = prod[23:8];
      end
   endfunction

   // align a sample to its codec width, zeroing low bits
   function [15:0] align;
      input [15:0] smp;
      input comp;
      input alaw;
      begin
         if (!comp) begin
            align = smp;
         end else if (alaw) begin
            align = {smp[15:3], 3'b000};
         end else begin
            align = {smp[15:2], 2'b00};
         end
      end
   endfunction

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [3:0] ctrl_reg;
   reg [15:0] play_vol_reg;
   reg [15:0] rec_vol_reg;
   reg [15:0] min_gain_reg;
   reg [15:0] max_gain_reg;
   reg [15:0] start_gain_reg;
   reg [15:0] hold_time_reg;
   reg [15:0] attack_tc_reg;
   reg [15:0] decay_tc_reg;
   reg [14:0] thresh_reg;
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [15:0] gain_reg;
   reg [15:0] gain_next;
   reg [15:0] hold_cnt_reg;
   reg [15:0] hold_cnt_next;
   reg [17:0] step_cnt_reg;
   reg [15:0] rate_cnt_reg;
   reg [15:0] rate_cnt_next;
   reg [31:0] rdata_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg far_sync1_reg;
   reg far_sync2_reg;

   wire agc_on = ctrl_reg[`SVAG_CTRL_AGC_EN];
   wire spkr = ctrl_reg[`SVAG_CTRL_SPKR];
   wire alaw = ctrl_reg[`SVAG_CTRL_ALAW];
   wire comp = ctrl_reg[`SVAG_CTRL_COMP];

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   // zero wait states, always okay; writes land in the data phase
   // the bus is not held off while clk_en is low: do not access then
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   wire take = hsel & hready & htrans[1];

   // read mux for the addressed word, unmapped reads zero
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (haddr[7:0])
         `SVAG_OFF_CTRL: rd_mux = {28'h0000000, ctrl_reg};
         `SVAG_OFF_PLAY_VOL: rd_mux = {16'h0000, play_vol_reg};
         `SVAG_OFF_REC_VOL: rd_mux = {16'h0000, rec_vol_reg};
         `SVAG_OFF_MIN_GAIN: rd_mux = {16'h0000, min_gain_reg};
         `SVAG_OFF_MAX_GAIN: rd_mux = {16'h0000, max_gain_reg};
         `SVAG_OFF_START_GAIN: rd_mux = {16'h0000, start_gain_reg};
         `SVAG_OFF_HOLD_TIME: rd_mux = {16'h0000, hold_time_reg};
         `SVAG_OFF_ATTACK_TC: rd_mux = {16'h0000, attack_tc_reg};
         `SVAG_OFF_DECAY_TC: rd_mux = {16'h0000, decay_tc_reg};
         `SVAG_OFF_THRESHOLD: rd_mux = {17'h00000, thresh_reg};
         `SVAG_OFF_STATUS: rd_mux = {12'h000, hold_cnt_reg, state_reg};
         `SVAG_OFF_GAIN: rd_mux = {16'h0000, gain_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // address capture and register writes; record volume always
   // stored, even while the agc overrides it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= 32'h00000000;
         ctrl_reg <= 4'h0;
         play_vol_reg <= `SVAG_RST_VOL;
         rec_vol_reg <= `SVAG_RST_VOL;
         min_gain_reg <= `SVAG_RST_MIN_GAIN;
         max_gain_reg <= `SVAG_RST_MAX_GAIN;
         start_gain_reg <= `SVAG_RST_START_GAIN;
         hold_time_reg <= `SVAG_RST_HOLD_TIME;
         attack_tc_reg <= `SVAG_RST_ATTACK_TC;
         decay_tc_reg <= `SVAG_RST_DECAY_TC;
         thresh_reg <= THRESH_RST[14:0];
      end else if (clk_en) begin
         if (hready) begin
            wr_pend_reg <= take & hwrite;
            wr_addr_reg <= haddr[7:0];
            if (take & !hwrite) begin
               rdata_reg <= rd_mux;
            end
         end
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               `SVAG_OFF_CTRL: ctrl_reg <= hwdata[3:0];
               `SVAG_OFF_PLAY_VOL: play_vol_reg <= hwdata[15:0];
               `SVAG_OFF_REC_VOL: rec_vol_reg <= hwdata[15:0];
               `SVAG_OFF_MIN_GAIN: min_gain_reg <= hwdata[15:0];
               `SVAG_OFF_MAX_GAIN: max_gain_reg <= hwdata[15:0];
               `SVAG_OFF_START_GAIN: start_gain_reg <= hwdata[15:0];
               `SVAG_OFF_HOLD_TIME: hold_time_reg <= hwdata[15:0];
               `SVAG_OFF_ATTACK_TC: attack_tc_reg <= hwdata[15:0];
               `SVAG_OFF_DECAY_TC: decay_tc_reg <= hwdata[15:0];
               `SVAG_OFF_THRESHOLD: thresh_reg <= hwdata[14:0];
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // far-end flag synchroniser
   // ------------------------------------------------------------
   // comes from the echo canceller, treated as foreign timing
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         far_sync1_reg <= 1'b0;
         far_sync2_reg <= 1'b0;
      end else if (clk_en) begin
         far_sync1_reg <= far_end_talk;
         far_sync2_reg <= far_sync1_reg;
      end
   end

   // ------------------------------------------------------------
   // record path datapath
   // ------------------------------------------------------------
   wire [15:0] rec_in = align(rec_sample, comp, alaw);
   wire [15:0] agc_out = q8_scale(rec_in, gain_reg);
   wire [15:0] agc_mag = agc_out[15] ? (~agc_out + 16'h0001) : agc_out;
   wire over = agc_mag > {1'b0, thresh_reg};

   // 250 us tick for the hold counter
   wire hold_tick = (step_cnt_reg == HOLD_STEP_CYC - 1);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_cnt_reg <= 18'h00000;
      end else if (clk_en) begin
         if (state_reg != ST_HOLD || hold_tick) begin
            step_cnt_reg <= 18'h00000;
         end else begin
            step_cnt_reg <= step_cnt_reg + 18'h00001;
         end
      end
   end

   // gain step sizes; far-end talk shrinks the rise step
   wire [15:0] dn_step = (gain_reg >> 4) + 16'h0001;
   wire [15:0] up_base = (gain_reg >> 6) + 16'h0001;
   wire [15:0] up_step = far_sync2_reg ?
                         (up_base >> `SVAG_FAR_SLOW_SHIFT) : up_base;
   wire [16:0] up_sum = {1'b0, gain_reg} + {1'b0, up_step};
   // floor test one bit wider, so a high minimum cannot wrap
   wire [16:0] dn_floor = {1'b0, min_gain_reg} + {1'b0, dn_step};

   // ------------------------------------------------------------
   // agc phase machine
   // ------------------------------------------------------------
   // one gain step every time-constant + 1 samples in that phase
   always @* begin
      state_next = state_reg;
      gain_next = gain_reg;
      hold_cnt_next = hold_cnt_reg;
      rate_cnt_next = rate_cnt_reg;
      case (state_reg)
         ST_OFF: begin
            if (agc_on) begin
               state_next = ST_DECAY;
               gain_next = start_gain_reg;
               rate_cnt_next = 16'h0000;
            end
         end
         ST_ATTACK: begin
            if (rec_valid) begin
               if (!over) begin
                  state_next = ST_HOLD;
                  hold_cnt_next = hold_time_reg;
               end else if (rate_cnt_reg >= attack_tc_reg) begin
                  rate_cnt_next = 16'h0000;
                  if ({1'b0, gain_reg} < dn_floor) begin
                     gain_next = min_gain_reg;
                  end else begin
                     gain_next = gain_reg - dn_step;
                  end
               end else begin
                  rate_cnt_next = rate_cnt_reg + 16'h0001;
               end
            end
         end
         ST_HOLD: begin
            if (rec_valid && over) begin
               state_next = ST_ATTACK;
               rate_cnt_next = 16'h0000;
            end else if (hold_cnt_reg == 16'h0000) begin
               state_next = ST_DECAY;
               rate_cnt_next = 16'h0000;
            end else if (hold_tick) begin
               hold_cnt_next = hold_cnt_reg - 16'h0001;
            end
         end
         ST_DECAY: begin
            if (rec_valid) begin
               if (over) begin
                  state_next = ST_ATTACK;
                  rate_cnt_next = 16'h0000;
               end else if (rate_cnt_reg >= decay_tc_reg) begin
                  rate_cnt_next = 16'h0000;
                  if (up_sum > {1'b0, max_gain_reg}) begin
                     gain_next = max_gain_reg;
                  end else begin
                     gain_next = up_sum[15:0];
                  end
               end else begin
                  rate_cnt_next = rate_cnt_reg + 16'h0001;
               end
            end
         end
         default: state_next = ST_OFF;
      endcase
      if (!agc_on) begin
         state_next = ST_OFF;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_OFF;
         gain_reg <= 16'h0000;
         hold_cnt_reg <= 16'h0000;
         rate_cnt_reg <= 16'h0000;
      end else if (clk_en) begin
         state_reg <= state_next;
         gain_reg <= gain_next;
         hold_cnt_reg <= hold_cnt_next;
         rate_cnt_reg <= rate_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // sample outputs
   // ------------------------------------------------------------
   // one cycle latency; agc replaces the record volume while on
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rec_out_valid <= 1'b0;
         rec_out_sample <= 16'h0000;
         play_out_valid <= 1'b0;
         play_out_sample <= 16'h0000;
      end else if (clk_en) begin
         rec_out_valid <= rec_valid;
         play_out_valid <= play_valid;
         if (rec_valid) begin
            if (spkr) begin
               rec_out_sample <= rec_in;
            end else if (state_reg != ST_OFF) begin
               rec_out_sample <= agc_out;
            end else begin
               rec_out_sample <= q8_scale(rec_in, rec_vol_reg);
            end
         end
         if (play_valid) begin
            if (spkr) begin
               play_out_sample <= align(play_sample, comp, alaw);
            end else begin
               play_out_sample <= align(q8_scale(play_sample,
                                  play_vol_reg), comp, alaw);
            end
         end
      end
   end

endmodule

// File: svag_core_checker.sv
/* port checker for the speech gain block: sample answer timing and
   bus response. assumes one clock hclk, async active-low hresetn. */
`timescale 1ns/10ps
module svag_core_checker #(
   parameter HOLD_STEP_CYC = 62500
) (
   input logic hclk,
   input logic hresetn,
   input logic clk_en,
   input logic hreadyout,
   input logic hresp,
   input logic rec_valid,
   input logic rec_out_valid,
   input logic [15:0] rec_out_sample,
   input logic play_valid,
   input logic play_out_valid,
   input logic [15:0] play_out_sample
);
   // ------------------------------------------------------------
   // assertions, all on hclk
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // every accepted sample answers exactly one cycle later
   a_rec_answer: assert property (
      rec_valid && clk_en |=> rec_out_valid)
      else $error("record answer missing");
   a_play_answer: assert property (
      play_valid && clk_en |=> play_out_valid)
      else $error("playback answer missing");
   a_rec_cause: assert property (
      rec_out_valid && $past(clk_en) |-> $past(rec_valid))
      else $error("record answer without sample");
   a_play_cause: assert property (
      play_out_valid && $past(clk_en) |-> $past(play_valid))
      else $error("playback answer without sample");
   // result words only move together with their strobe
   a_rec_hold: assert property (
      $changed(rec_out_sample) |-> rec_out_valid)
      else $error("record result moved without strobe");
   a_play_hold: assert property (
      $changed(play_out_sample) |-> play_out_valid)
      else $error("playback result moved without strobe");
   // zero-wait slave, okay only
   a_bus_ready: assert property (hreadyout)
      else $error("slave not ready");
   a_bus_okay: assert property (!hresp)
      else $error("slave error response");
   c_rec: cover property (rec_valid && clk_en ##1 rec_out_valid);
   c_play: cover property (play_valid && clk_en ##1 play_out_valid);
   c_back: cover property (rec_valid ##2 rec_valid);
endmodule

bind svag_core svag_core_checker #(.HOLD_STEP_CYC(HOLD_STEP_CYC)) chk (
   .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
   .hreadyout(hreadyout), .hresp(hresp), .rec_valid(rec_valid),
   .rec_out_valid(rec_out_valid), .rec_out_sample(rec_out_sample),
   .play_valid(play_valid), .play_out_valid(play_out_valid),
   .play_out_sample(play_out_sample)
);

// File: svag_codec_model.sv
/* codec side model: one-cycle sample strobes in, answers collected.
   assumes send is called just after a rising edge of hclk. */
`timescale 1ns/10ps
module svag_codec_model (
   input logic hclk,
   output logic rec_valid,
   output logic [15:0] rec_sample,
   output logic play_valid,
   output logic [15:0] play_sample,
   input logic rec_out_valid,
   input logic [15:0] rec_out_sample,
   input logic play_out_valid,
   input logic [15:0] play_out_sample
);
   // ------------------------------------------------------------
   // sample exchange
   // ------------------------------------------------------------
   initial begin
      rec_valid = 1'b0;
      play_valid = 1'b0;
      rec_sample = 16'h0000;
      play_sample = 16'h0000;
   end
   // strobe one word, then wait a bounded span for its answer
   task send(input logic rec, input logic [15:0] s,
             output logic [15:0] q);
      int n;
      n = 0;
      q = 16'hXXXX;
      rec_valid <= rec;
      play_valid <= !rec;
      rec_sample <= s;
      play_sample <= s;
      @(posedge hclk);
      rec_valid <= 1'b0;
      play_valid <= 1'b0;
      // line not held after the strobe: show the inverse, not a copy
      rec_sample <= ~s;
      play_sample <= ~s;
      do begin
         @(posedge hclk);
         n++;
         if (rec && rec_out_valid === 1'b1) q = rec_out_sample;
         if (!rec && play_out_valid === 1'b1) q = play_out_sample;
      end while (q === 16'hXXXX && n < 4);
   endtask
endmodule

// File: tb_speech_volume_and_agc.sv
/* self-checking bench: ahb-lite register access plus codec samples.
   assumes hold step shortened to 4 cycles for a short run. */
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_speech_volume_and_agc;
   logic hclk, hresetn, clk_en, hsel, hwrite, far_end_talk;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] r, g1, g2, g3, g4;
   wire [31:0] hrdata;
   wire hreadyout, hresp, rec_valid, rec_out_valid, play_valid;
   wire play_out_valid;
   wire [15:0] rec_sample, rec_out_sample, play_sample, play_out_sample;
   int failures, checks_done, i;
   logic [31:0] rst_tab [0:10] = '{32'h0, 32'h100, 32'h100, 32'h20,
      32'h1000, 32'h800, 32'h1F40, 32'h5, 32'hD, 32'h2000, 32'h1};
   svag_core #(.HOLD_STEP_CYC(4)) uut (.hclk(hclk), .hresetn(hresetn),
      .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rec_valid(rec_valid), .rec_sample(rec_sample),
      .rec_out_valid(rec_out_valid), .rec_out_sample(rec_out_sample),
      .play_valid(play_valid), .play_sample(play_sample),
      .play_out_valid(play_out_valid),
      .play_out_sample(play_out_sample), .far_end_talk(far_end_talk));
   svag_codec_model codec (.hclk(hclk), .rec_valid(rec_valid),
      .rec_sample(rec_sample), .play_valid(play_valid),
      .play_sample(play_sample), .rec_out_valid(rec_out_valid),
      .rec_out_sample(rec_out_sample), .play_out_valid(play_out_valid),
      .play_out_sample(play_out_sample));
   // ------------------------------------------------------------
   // bus and sample tasks
   // ------------------------------------------------------------
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task rs(input logic [15:0] s);
      codec.send(1'b1, s, r);
   endtask
   task gain(output logic [15:0] g);
      rd(8'h2C);
      g = q[15:0];
   endtask
   task st(input logic [3:0] e);
      rd(8'h28);
      `CHK(q[3:0], e)
   endtask
   // set a volume, push one sample, compare the answer
   task sv(input logic rec, input logic [15:0] vol, s, e);
      wr(rec ? 8'h08 : 8'h04, {16'h0, vol});
      codec.send(rec, s, r);
      `CHK(r, e)
   endtask
   // every register except the gain word against its reset value
   task chk_reset;
      for (i = 0; i < 11; i++) begin
         rd(8'(i * 4));
         `CHK(q, rst_tab[i])
      end
   endtask
   task end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // watchdog, far beyond the expected few hundred cycles
   initial begin
      #100000;
      failures++;
      end_sim;
   end
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, far_end_talk} = 4'h0;
      {haddr, hwdata, htrans} = 66'h0;
      hsize = 3'b010;
      clk_en = 1'b1;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_reset;
      rd(8'h30);
      `CHK(q, 32'h0)
      sv(0, 16'h0100, 16'h0400, 16'h0400);
      sv(0, 16'h0200, 16'h0400, 16'h0800);
      sv(1, 16'h0080, 16'h0400, 16'h0200);
      sv(1, 16'h0080, 16'hFFFD, 16'hFFFE);
      sv(0, 16'h0200, 16'h4000, 16'h8000);
      sv(1, 16'h0180, 16'h0100, 16'h0180);
      wr(8'h00, 32'h8);
      sv(1, 16'h0100, 16'h1237, 16'h1234);
      sv(0, 16'h0100, 16'h1237, 16'h1234);
      wr(8'h00, 32'hC);
      sv(1, 16'h0100, 16'h1237, 16'h1230);
      wr(8'h00, 32'h2);
      sv(0, 16'h0200, 16'h0400, 16'h0400);
      sv(1, 16'h0200, 16'h0400, 16'h0400);
      // agc pinned at unity: record volume bypassed but kept
      wr(8'h0C, 32'h100);
      wr(8'h10, 32'h100);
      wr(8'h14, 32'h100);
      wr(8'h00, 32'h1);
      wr(8'h08, 32'h180);
      rs(16'h0400);
      `CHK(r, 16'h0400)
      wr(8'h00, 32'h0);
      rd(8'h08);
      `CHK(q, 32'h180)
      rs(16'h0400);
      `CHK(r, 16'h0600)
      // attack, hold, decay with fast constants
      wr(8'h0C, 32'h20);
      wr(8'h10, 32'h1000);
      wr(8'h14, 32'h800);
      wr(8'h24, 32'h400);
      wr(8'h18, 32'h8);
      wr(8'h1C, 32'h0);
      wr(8'h20, 32'h0);
      wr(8'h00, 32'h1);
      // start gain is loaded one cycle after the enable lands
      @(posedge hclk);
      gain(g1);
      `CHK(g1, 16'h0800)
      st(4'h8);
      rs(16'h0100);
      rs(16'h0100);
      st(4'h2);
      gain(g2);
      `CHK(g2 < g1, 1'b1)
      rs(16'h0010);
      st(4'h4);
      gain(g3);
      `CHK(g3, g2)
      rs(16'h0100);
      st(4'h2);
      rs(16'h0010);
      st(4'h4);
      repeat (20) @(posedge hclk);
      st(4'h4);
      repeat (16) @(posedge hclk);
      st(4'h8);
      // gain climbs, slower while the far end talks
      gain(g1);
      rs(16'h0010);
      rs(16'h0010);
      gain(g2);
      `CHK(g2 > g1, 1'b1)
      far_end_talk <= 1'b1;
      repeat (4) @(posedge hclk);
      gain(g3);
      rs(16'h0010);
      rs(16'h0010);
      gain(g4);
      `CHK((g4 - g3) < (g2 - g1), 1'b1)
      far_end_talk <= 1'b0;
      wr(8'h10, 32'h900);
      for (i = 0; i < 40; i++) rs(16'h0010);
      gain(g1);
      `CHK(g1, 16'h0900)
      rs(16'h0100);
      st(4'h2);
      wr(8'h0C, 32'h600);
      for (i = 0; i < 40; i++) rs(16'h0100);
      wr(8'h2C, 32'h1234);
      gain(g1);
      `CHK(g1, 16'h0600)
      // reset in mid-run with the agc busy: all back to defaults
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_reset;
      end_sim;
   end
endmodule
